// ---- hdl/dsk_pkg.sv ----
// Shared types and constants for the decimal-adjust / decrement-skip execution block
package dsk_pkg;

  localparam int unsigned DSK_DATA_W  = 8;
  localparam int unsigned DSK_ADDR_W  = 7;
  localparam int unsigned DSK_NIB_W   = 4;
  localparam int unsigned DSK_HI_LSB  = 4;

  localparam logic [7:0]  DSK_ACC_RST  = 8'h00;
  localparam logic        DSK_FLAG_RST = 1'b0;
  localparam logic        DSK_GIE_RST  = 1'b0;
  localparam logic [3:0]  DSK_NIB_MAX  = 4'h9;
  localparam logic [4:0]  DSK_NIB_FIX  = 5'h06;
  localparam logic [7:0]  DSK_ONE      = 8'h01;
  localparam logic [7:0]  DSK_ZERO     = 8'h00;
  localparam logic        DSK_DEST_ACC = 1'b0;
  localparam logic        DSK_DEST_REG = 1'b1;

  typedef enum logic [2:0] {
    op_nop,
    add_accumulator_register_op,
    decimal_adjust_op,
    decrement_skip_zero_op,
    global_irq_disable_op,
    global_irq_enable_op
  } dsk_op_e;

  typedef struct packed {
    dsk_op_e         op;
    logic [6:0]      file_addr;
    logic            dest;
  } dsk_instr_s;

  typedef struct packed {
    logic            we;
    logic [6:0]      addr;
    logic [7:0]      data;
  } dsk_fwrite_s;

  typedef struct packed {
    logic            carry;
    logic            half_carry;
    logic            zero;
  } dsk_flags_s;

endpackage : dsk_pkg

// ---- hdl/dsk_bcd_digit.sv ----
// One decimal digit correction stage
`timescale 1ns/10ps
`default_nettype none
module dsk_bcd_digit
  import dsk_pkg::*;
(
  // Digit in
  input  wire logic [3:0] nib,
  input  wire logic       carry_in,
  input  wire logic       force_fix,
  // Digit out
  output logic      [3:0] nib_out,
  output logic            carry_out
);

  logic [4:0] sum;
  logic [4:0] fixed;

  always_comb begin
    sum       = {1'b0, nib} + {4'h0, carry_in};
    if ((sum > {1'b0, DSK_NIB_MAX}) || force_fix) begin
      fixed = sum + DSK_NIB_FIX;
    end else begin
      fixed = sum;
    end
    nib_out   = fixed[3:0];
    carry_out = fixed[4];
  end

endmodule : dsk_bcd_digit
`default_nettype wire

// ---- hdl/dsk_exec_core.sv ----
// Execution of add, decimal adjust, decrement-skip and global interrupt enable/disable
`timescale 1ns/10ps
`default_nettype none
module dsk_exec_core
  import dsk_pkg::*;
#(
  // Widths the instruction fields and the two-digit adjust are built for
  parameter int unsigned DATA_W = DSK_DATA_W,
  parameter int unsigned ADDR_W = DSK_ADDR_W
)
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Instruction slot
  input  wire logic        instr_valid,
  input  wire dsk_instr_s  instr,
  input  wire logic [7:0]  file_rdata,
  // File register write
  output dsk_fwrite_s      fwrite_q,
  // Core state
  output logic [7:0]       working_accumulator_q,
  output dsk_flags_s       flags_q,
  output logic             global_interrupt_enable_bit_q,
  // Slot status
  output logic             squash_q,
  output logic             discarded_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Decimal correction

  logic [3:0] lo_nib;
  logic [3:0] hi_nib;
  logic       lo_carry;
  logic       hi_carry;

  dsk_bcd_digit u_lo (
    .nib       (working_accumulator_q[3:0]),
    .carry_in  (1'b0),
    .force_fix (flags_q.half_carry),
    .nib_out   (lo_nib),
    .carry_out (lo_carry)
  );

  dsk_bcd_digit u_hi (
    .nib       (working_accumulator_q[7:4]),
    .carry_in  (lo_carry),
    .force_fix (flags_q.carry),
    .nib_out   (hi_nib),
    .carry_out (hi_carry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Parameter checks

  if (DATA_W != 2 * DSK_NIB_W) begin : g_data_w_check
    $error("dsk_exec_core: DATA_W must hold exactly two decimal digits");
  end
  if (ADDR_W != DSK_ADDR_W) begin : g_addr_w_check
    $error("dsk_exec_core: ADDR_W must match the instruction address field");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slot decode

  logic                 execute;
  logic                 drop_slot;
  logic                 is_add;
  logic                 is_adjust;
  logic                 is_decskip;
  logic                 is_irq_off;
  logic                 is_irq_on;
  logic                 writes_result;
  logic                 to_register;
  logic [DATA_W:0]      add_sum;
  logic [DSK_NIB_W:0]   add_low;
  logic [DATA_W-1:0]    dec_val;
  logic [DATA_W-1:0]    result;
  logic                 result_zero;

  always_comb begin
    // Prefetched slot after a taken skip runs as a no-op
    execute    = instr_valid && !squash_q;
    drop_slot  = instr_valid && squash_q;
    is_add     = 1'b0;
    is_adjust  = 1'b0;
    is_decskip = 1'b0;
    is_irq_off = 1'b0;
    is_irq_on  = 1'b0;
    if (execute) begin
      case (instr.op)
        add_accumulator_register_op: begin
          is_add = 1'b1;
        end
        decimal_adjust_op: begin
          is_adjust = 1'b1;
        end
        decrement_skip_zero_op: begin
          is_decskip = 1'b1;
        end
        global_irq_disable_op: begin
          is_irq_off = 1'b1;
        end
        global_irq_enable_op: begin
          is_irq_on = 1'b1;
        end
        // Unknown codes and the no-op change nothing
        default: begin
        end
      endcase
    end
    add_sum       = {1'b0, working_accumulator_q} + {1'b0, file_rdata};
    add_low       = {1'b0, working_accumulator_q[DSK_NIB_W-1:0]} + {1'b0, file_rdata[DSK_NIB_W-1:0]};
    dec_val       = file_rdata - DSK_ONE;
    result        = is_add ? add_sum[DATA_W-1:0] : dec_val;
    result_zero   = (result == DSK_ZERO);
    writes_result = is_add || is_decskip;
    to_register   = writes_result && (instr.dest == DSK_DEST_REG);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and flags

  logic [DATA_W-1:0]    acc_d;
  dsk_flags_s           flags_d;

  always_comb begin
    acc_d   = working_accumulator_q;
    flags_d = flags_q;
    if (is_add) begin
      flags_d.carry      = add_sum[DATA_W];
      flags_d.half_carry = add_low[DSK_NIB_W];
      flags_d.zero       = result_zero;
    end
    if (is_decskip) begin
      flags_d.zero = result_zero;
    end
    if (writes_result && !to_register) begin
      acc_d = result;
    end
    if (is_adjust) begin
      acc_d         = {hi_nib, lo_nib};
      flags_d.carry = hi_carry || flags_q.carry;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      working_accumulator_q <= DSK_ACC_RST;
      flags_q               <= '{carry: DSK_FLAG_RST, half_carry: DSK_FLAG_RST, zero: DSK_FLAG_RST};
    end else begin
      working_accumulator_q <= acc_d;
      flags_q               <= flags_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Global interrupt enable

  logic                 gie_d;

  always_comb begin
    gie_d = global_interrupt_enable_bit_q;
    if (is_irq_off) begin
      gie_d = 1'b0;
    end else if (is_irq_on) begin
      gie_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      global_interrupt_enable_bit_q <= DSK_GIE_RST;
    end else begin
      global_interrupt_enable_bit_q <= gie_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skip of the prefetched slot

  logic                 squash_d;
  logic                 discarded_d;

  always_comb begin
    squash_d    = squash_q;
    discarded_d = drop_slot;
    if (drop_slot) begin
      squash_d = 1'b0;
    end else if (is_decskip) begin
      squash_d = result_zero;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      squash_q    <= 1'b0;
      discarded_q <= 1'b0;
    end else begin
      squash_q    <= squash_d;
      discarded_q <= discarded_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // File register write

  dsk_fwrite_s          fwrite_d;

  always_comb begin
    fwrite_d = '0;
    if (to_register) begin
      fwrite_d.we   = 1'b1;
      fwrite_d.addr = instr.file_addr;
      fwrite_d.data = result;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      fwrite_q <= '0;
    end else begin
      fwrite_q <= fwrite_d;
    end
  end

endmodule : dsk_exec_core
`default_nettype wire

// ---- bench/dsk_exec_monitor.sv ----
// Checker on the execution block ports
`timescale 1ns/10ps
`default_nettype none
module dsk_exec_monitor
  import dsk_pkg::*;
(
  // Inputs
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        instr_valid,
  input wire dsk_instr_s  instr,
  input wire logic [7:0]  file_rdata,
  // Outputs
  input wire dsk_fwrite_s fwrite_q,
  input wire logic [7:0]  working_accumulator_q,
  input wire dsk_flags_s  flags_q,
  input wire logic        global_interrupt_enable_bit_q,
  input wire logic        squash_q,
  input wire logic        discarded_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence take_s; instr_valid && !squash_q; endsequence
  sequence dec_s; take_s ##0 instr.op == decrement_skip_zero_op; endsequence
  dec_reg_a: assert property (dec_s ##0 instr.dest |=> fwrite_q.we && fwrite_q.data == $past(file_rdata) - 8'h01)
    else $error("bad register write");
  dec_acc_a: assert property (dec_s ##0 !instr.dest |=> !fwrite_q.we && working_accumulator_q == $past(file_rdata) - 8'h01)
    else $error("bad accumulator write");
  skip_next_a: assert property (dec_s ##0 file_rdata == 8'h01 ##1 instr_valid |=> discarded_q)
    else $error("slot not dropped");
  no_skip_a: assert property (dec_s ##0 file_rdata != 8'h01 |=> !squash_q)
    else $error("skip on nonzero");
  drop_slot_a: assert property (instr_valid && squash_q |=> !fwrite_q.we && $stable(working_accumulator_q))
    else $error("dropped slot acted");
  irq_off_a: assert property (take_s ##0 instr.op == global_irq_disable_op |=> !global_interrupt_enable_bit_q)
    else $error("enable not cleared");
  adjust_bcd_a: assert property (take_s ##0 instr.op == decimal_adjust_op
    |=> working_accumulator_q[3:0] <= 4'h9 && working_accumulator_q[7:4] <= 4'h9)
    else $error("digit above nine");
  skip_set_a: assert property (dec_s ##0 file_rdata == 8'h01 |=> squash_q && flags_q.zero)
    else $error("skip not armed");
endmodule : dsk_exec_monitor
bind dsk_exec_core dsk_exec_monitor mon (.*);
`default_nettype wire

// ---- bench/dsk_file_model.sv ----
// File register model feeding the execution block
`timescale 1ns/10ps
`default_nettype none
module dsk_file_model
  import dsk_pkg::*;
(
  // Core side
  input  wire logic        clk_sys,
  input  wire dsk_instr_s  instr,
  input  wire dsk_fwrite_s fwrite_q,
  output logic [7:0]       file_rdata
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i < 112 ? i : i & 3);
  assign file_rdata = mem[instr.file_addr];
  always @(posedge clk_sys) if (fwrite_q.we) mem[fwrite_q.addr] <= fwrite_q.data;
endmodule : dsk_file_model
`default_nettype wire

// ---- bench/decimal_adjust_and_decrement_skip_tb.sv ----
// Self-checking bench for the execution block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; $display("mismatch %0t %h %h", $time, g, e); end end
module decimal_adjust_and_decrement_skip_tb import dsk_pkg::*;;
  logic        clk_sys = 1'b0, rstn = 1'b0, instr_valid = 1'b0;
  dsk_instr_s  instr = '0;
  dsk_fwrite_s fwrite_q;
  dsk_flags_s  flags_q;
  logic [7:0]  file_rdata, working_accumulator_q, acc, x, y, sh [128];
  logic        global_interrupt_enable_bit_q, squash_q, discarded_q, c, hc, global_interrupt_enable_bit, sq, z;
  logic [28:0] q [$], ev, got;
  int          mismatches = 0, checked = 0;
  dsk_exec_core uut (.*);
  dsk_file_model fm (.*);
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic issue(input dsk_op_e o, input logic [6:0] a, input logic d);
    logic [8:0] s;
    logic [7:0] r;
    logic       we, dc;
    we = 1'b0;
    r = 8'h00;
    dc = sq;
    if (sq) sq = 1'b0;
    else case (o)
      add_accumulator_register_op: begin
        {hc, r[3:0]} = acc[3:0] + sh[a][3:0];
        {c, acc} = acc + sh[a];
        z = acc == 8'h00;
      end
      decimal_adjust_op: begin
        s = {1'b0, acc} + ((acc[3:0] > 4'h9 || hc) ? 9'h006 : 9'h000);
        s = s + ((s[7:4] > 4'h9 || c) ? 9'h060 : 9'h000);
        c = c | s[8];
        acc = s[7:0];
      end
      decrement_skip_zero_op: begin
        r = sh[a] - 8'h01;
        sq = r == 8'h00;
        z = sq;
        we = d;
        if (d) sh[a] = r;
        else acc = r;
      end
      global_irq_disable_op: global_interrupt_enable_bit = 1'b0;
      global_irq_enable_op: global_interrupt_enable_bit = 1'b1;
      default: ;
    endcase
    instr <= '{o, a, d};
    instr_valid <= 1'b1;
    @(posedge clk_sys);
    q.push_back({acc, c, hc, z, global_interrupt_enable_bit, we, a & {7{we}}, r & {8{we}}, dc});
  endtask : issue
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  always @(negedge clk_sys) if (q.size() > 0) begin
    ev = q.pop_front();
    got = {working_accumulator_q, flags_q, global_interrupt_enable_bit_q, fwrite_q.we,
      fwrite_q.addr & {7{fwrite_q.we}}, fwrite_q.data & {8{fwrite_q.we}}, discarded_q};
    `CHK(got, ev)
  end
  initial begin
    #(25 * 3000);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 128; i++) sh[i] = 8'(i < 112 ? i : i & 3);
    {acc, c, hc, global_interrupt_enable_bit, sq, z} = '0;
    void'($urandom(32'h185107b7));
    repeat (8) @(posedge clk_sys);
    `CHK({working_accumulator_q, flags_q, global_interrupt_enable_bit_q, squash_q, discarded_q, fwrite_q}, 30'h0)
    rstn <= 1'b1;
    $display("reset test done");
    for (int n = 0; n < 40; n++) begin
      x = {4'($urandom % 6), 4'($urandom % 10)};
      y = {4'($urandom % 6), 4'($urandom % 10)};
      issue(global_irq_disable_op, 7'h00, 1'b0);
      issue(decrement_skip_zero_op, 7'(x + 8'h01), 1'b0);
      issue(add_accumulator_register_op, y[6:0], 1'b0);
      issue(decimal_adjust_op, 7'h00, 1'b0);
      issue(global_irq_enable_op, 7'h00, 1'b0);
      issue(op_nop, 7'($urandom), 1'($urandom));
      issue(decrement_skip_zero_op, 7'h70 + 7'($urandom % 16), 1'($urandom));
      if ($urandom % 2) begin
        instr_valid <= 1'b0;
        @(posedge clk_sys);
      end
    end
    instr_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    $display("sequence test done");
    tally_and_finish();
  end
endmodule : decimal_adjust_and_decrement_skip_tb
`default_nettype wire
